//--- shared/eqgsl_pkg.sv
// constants and types of the equalizer gain serial loader
//
// Summary of operation
// - Every setting command is one ten-bit word on the serial data pin holding channel, band and gain.
// - The shift register takes the serial data pin on each rising serial clock edge.
// - Bits are shifted in only while the active-low select pin is low.
// - The rising edge of the select pin moves the shifted word into the addressed gain latches; the code rejects such words until a flat command after reset.
// - The all-ones word sets every band of both channels to flat gain at once instead of being decoded.
// - Words travel least significant bit first, magnitude first and channel bits last.
// - Bits 0-2 are magnitude, bit 3 sign, bits 4-7 band code, bit 8 left select, bit 9 right select.
// - Gain is a sign (0 boost, 1 cut) plus a magnitude in 3 dB steps from 000 (0 dB) to 110 (18 dB); the code rejects a cut with magnitude 000.
// - Band codes 0001 to 1011 select bands 1 to 11.
// - Right bit alone picks the right channel, left bit alone the left, both bits both channels.
// - Twenty-two gain latches, one per band and channel, hold their value until addressed or flat-set.
// - Nothing is initialised at power-up, so latch contents start undefined.
`default_nettype none

package eqgsl_pkg;
	// serial word layout
	localparam int WORD_W    = 10;
	localparam int MAG_W     = 3;
	localparam int BAND_W    = 4;
	localparam int NUM_BANDS = 11;
	localparam logic [WORD_W-1:0] FLAT_WORD  = 10'h3FF;
	localparam logic [BAND_W-1:0] BAND_FIRST = 4'h1;
	localparam logic [BAND_W-1:0] BAND_LAST  = 4'hB;
	localparam logic [MAG_W-1:0]  MAG_MAX    = 3'h6;
	localparam logic [MAG_W-1:0]  MAG_ZERO   = 3'h0;

	// register map, byte addresses
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam logic [ADR_W-1:0] OFS_CTRL      = 8'h00;
	localparam logic [ADR_W-1:0] OFS_STATUS    = 8'h04;
	localparam logic [ADR_W-1:0] OFS_COUNT     = 8'h08;
	localparam logic [ADR_W-1:0] OFS_GAIN_BASE = 8'h40;
	localparam logic [ADR_W-1:0] OFS_GAIN_END  = 8'h6C;
	localparam int CTRL_ACCEPT_BIT = 0;
	localparam int CTRL_FLAT_BIT   = 1;
	localparam int STAT_INIT_BIT   = 16;
	localparam int STAT_REJ_BIT    = 17;
	localparam int GAIN_RIGHT_LSB  = 8;
	localparam int COUNT_W         = 16;
	localparam logic CTRL_ACCEPT_RESET = 1'b1;
	localparam logic SELECT_IDLE       = 1'b1;

	// one gain latch: sign then magnitude
	typedef struct packed {
		logic             sign;
		logic [MAG_W-1:0] magnitude;
	} eqgsl_gain_type;

	typedef eqgsl_gain_type [NUM_BANDS-1:0] eqgsl_bank_type;

	// serial word, msb first as packed
	typedef struct packed {
		logic              right;
		logic              left;
		logic [BAND_W-1:0] band;
		eqgsl_gain_type    gain;
	} eqgsl_word_type;

	localparam eqgsl_gain_type GAIN_FLAT = '{sign: 1'b0, magnitude: 3'h0};

	// classic wishbone request
	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [ADR_W-1:0] adr;
		logic [DAT_W-1:0] dat;
		logic [3:0]       sel;
	} eqgsl_wb_req_type;

	typedef enum {
		WB_IDLE,
		WB_FETCH,
		WB_ANSWER
	} eqgsl_wb_state_type;
endpackage

`default_nettype wire

//--- rtl/eqgsl_sync3.sv
// three-stage synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none

module eqgsl_sync3 #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic async_in,
	output logic      stage2_out,
	output logic      stage3_out
);
	logic stage1_ff;

	// first stage feeds only the second
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			stage1_ff  <= RST_VAL;
			stage2_out <= RST_VAL;
			stage3_out <= RST_VAL;
		end
		else
		begin
			stage1_ff  <= async_in;
			stage2_out <= stage1_ff;
			stage3_out <= stage2_out;
		end
	end
endmodule // eqgsl_sync3

`default_nettype wire

//--- rtl/eqgsl_gain_bank.sv
// bank of 22 gain latches with registered read port
`timescale 1ns/1ps
`default_nettype none

module eqgsl_gain_bank (
	input  wire logic                          clk_in,
	input  wire logic                          flat_in,
	input  wire logic                          wr_en_in,
	input  wire logic [eqgsl_pkg::BAND_W-1:0]  wr_band_in,
	input  wire logic                          wr_left_in,
	input  wire logic                          wr_right_in,
	input  wire eqgsl_pkg::eqgsl_gain_type     wr_gain_in,
	input  wire logic [eqgsl_pkg::BAND_W-1:0]  rd_index_in,
	output logic [2*(eqgsl_pkg::MAG_W+1)-1:0]  rd_data_out,
	output var eqgsl_pkg::eqgsl_bank_type      left_out,
	output var eqgsl_pkg::eqgsl_bank_type      right_out
);
	// latches carry no reset: contents undefined until flat-set
	always_ff @(posedge clk_in)
	begin
		for (int i = 0; i < eqgsl_pkg::NUM_BANDS; i++)
		begin
			// flat first, a word in the same cycle still lands
			if (flat_in)
			begin
				left_out[i]  <= eqgsl_pkg::GAIN_FLAT;
				right_out[i] <= eqgsl_pkg::GAIN_FLAT;
			end
			// only the addressed band and channel change
			if (wr_en_in && wr_band_in == 4'(i) + eqgsl_pkg::BAND_FIRST)
			begin
				if (wr_left_in)
					left_out[i] <= wr_gain_in;
				if (wr_right_in)
					right_out[i] <= wr_gain_in;
			end
		end
	end

	// read port, right gain in upper nibble
	always_ff @(posedge clk_in)
	begin
		if (rd_index_in < 4'(eqgsl_pkg::NUM_BANDS))
			rd_data_out <= {right_out[rd_index_in], left_out[rd_index_in]};
		else
			rd_data_out <= '0;
	end
endmodule // eqgsl_gain_bank

`default_nettype wire

//--- rtl/eqgsl_loader.sv
// serial word loader with gain latch bank and wishbone register slave
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module eqgsl_loader (
	input  wire logic                           clk_in,
	input  wire logic                           rstn_in,
	input  wire logic                           serial_clk_in,
	input  wire logic                           select_n_in,
	input  wire logic                           serial_data_input_in,
	input  wire eqgsl_pkg::eqgsl_wb_req_type    wb_req_in,
	output logic                                wb_ack_out,
	output logic [eqgsl_pkg::DAT_W-1:0]         wb_dat_out,
	output var eqgsl_pkg::eqgsl_bank_type       gain_left_out,
	output var eqgsl_pkg::eqgsl_bank_type       gain_right_out,
	output logic                                initialized_out
);
	// link side
	logic [eqgsl_pkg::WORD_W-1:0]  shift_ff;

	// select crossing
	logic                          sel_s2;
	logic                          sel_s3;
	logic                          sel_lvl_ff;
	logic                          sel_rise_ff;

	// captured word and decode
	eqgsl_pkg::eqgsl_word_type     word_ff;
	logic                          cap_ff;
	logic                          is_flat;
	logic                          band_ok;
	logic                          gain_ok;
	logic                          chan_ok;
	logic                          ser_flat;
	logic                          ser_wr;
	logic                          ser_rej;
	logic                          flat_all;

	// status and control
	logic                          accept_ff;
	logic                          soft_flat_ff;
	logic                          rej_ff;
	logic [eqgsl_pkg::WORD_W-1:0]  last_word_ff;
	logic [eqgsl_pkg::COUNT_W-1:0] count_ff;

	// bus slave
	eqgsl_pkg::eqgsl_wb_state_type wb_state_ff;
	eqgsl_pkg::eqgsl_wb_state_type nxt_wb_state;
	logic                          wb_req;
	logic                          wr_ctrl;
	logic                          gain_hit;
	logic [eqgsl_pkg::BAND_W-1:0]  rd_index;
	logic [2*(eqgsl_pkg::MAG_W+1)-1:0] bank_rd;
	logic [eqgsl_pkg::DAT_W-1:0]   nxt_rd;

	// latch bank
	eqgsl_pkg::eqgsl_bank_type     bank_left;
	eqgsl_pkg::eqgsl_bank_type     bank_right;

	// shift register on the serial clock, lsb arrives first, no reset
	always_ff @(posedge serial_clk_in)
	begin
		if (!select_n_in)
			shift_ff <= {serial_data_input_in, shift_ff[eqgsl_pkg::WORD_W-1:1]};
	end

	// select pin into the system clock
	eqgsl_sync3 #(
		.RST_VAL    (eqgsl_pkg::SELECT_IDLE)
	) u_sel_sync (
		.clk_in     (clk_in),
		.rstn_in    (rstn_in),
		.async_in   (select_n_in),
		.stage2_out (sel_s2),
		.stage3_out (sel_s3)
	);

	// level follows only when stages two and three agree
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sel_lvl_ff  <= eqgsl_pkg::SELECT_IDLE;
			sel_rise_ff <= 1'b0;
		end
		else
		begin
			if (sel_s2 == sel_s3)
				sel_lvl_ff <= sel_s2;
			sel_rise_ff <= (sel_s2 == sel_s3) && sel_s2 && !sel_lvl_ff;
		end
	end

	// shift register is quiet while select is high, so sample it here
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			word_ff <= '0;
			cap_ff  <= 1'b0;
		end
		else
		begin
			cap_ff <= sel_rise_ff;
			if (sel_rise_ff)
				word_ff <= eqgsl_pkg::eqgsl_word_type'(shift_ff);
		end
	end

	// word decode
	always_comb
	begin
		is_flat = (word_ff == eqgsl_pkg::eqgsl_word_type'(eqgsl_pkg::FLAT_WORD));
		band_ok = (word_ff.band >= eqgsl_pkg::BAND_FIRST)
			&& (word_ff.band <= eqgsl_pkg::BAND_LAST);
		gain_ok = (word_ff.gain.magnitude <= eqgsl_pkg::MAG_MAX)
			&& !(word_ff.gain.sign && word_ff.gain.magnitude == eqgsl_pkg::MAG_ZERO);
		chan_ok = word_ff.left || word_ff.right;
		ser_flat = cap_ff && accept_ff && is_flat;
		// ordinary words wait for the first flat command
		ser_wr = cap_ff && accept_ff && !is_flat && initialized_out
			&& band_ok && gain_ok && chan_ok;
		ser_rej = cap_ff && accept_ff && !is_flat && !ser_wr;
		flat_all = ser_flat || soft_flat_ff;
	end

	// the 22 latches
	eqgsl_gain_bank u_bank (
		.clk_in      (clk_in),
		.flat_in     (flat_all),
		.wr_en_in    (ser_wr),
		.wr_band_in  (word_ff.band),
		.wr_left_in  (word_ff.left),
		.wr_right_in (word_ff.right),
		.wr_gain_in  (word_ff.gain),
		.rd_index_in (rd_index),
		.rd_data_out (bank_rd),
		.left_out    (bank_left),
		.right_out   (bank_right)
	);

	// initialised once a flat command went through
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			initialized_out <= 1'b0;
		else if (flat_all)
			initialized_out <= 1'b1;
	end

	// gain outputs read zero until the bank holds defined values
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			gain_left_out  <= '0;
			gain_right_out <= '0;
		end
		else if (initialized_out)
		begin
			gain_left_out  <= bank_left;
			gain_right_out <= bank_right;
		end
		else
		begin
			gain_left_out  <= '0;
			gain_right_out <= '0;
		end
	end

	// status of the last serial word
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rej_ff       <= 1'b0;
			last_word_ff <= '0;
			count_ff     <= '0;
		end
		else
		begin
			if (cap_ff && accept_ff)
			begin
				rej_ff       <= ser_rej;
				last_word_ff <= word_ff;
			end
			if (ser_flat || ser_wr)
				count_ff <= count_ff + 16'h0001;
		end
	end

	// bus request and address decode
	always_comb
	begin
		wb_req = wb_req_in.cyc && wb_req_in.stb;
		gain_hit = (wb_req_in.adr >= eqgsl_pkg::OFS_GAIN_BASE)
			&& (wb_req_in.adr < eqgsl_pkg::OFS_GAIN_END)
			&& (wb_req_in.adr[1:0] == 2'h0);
		rd_index = 4'((wb_req_in.adr - eqgsl_pkg::OFS_GAIN_BASE) >> 2);
		wr_ctrl = wb_req_in.we && wb_req_in.sel[0] && (wb_req_in.adr == eqgsl_pkg::OFS_CTRL);
	end

	// slave states: fetch lets the bank read settle
	always_comb
	begin
		nxt_wb_state = wb_state_ff;
		case (wb_state_ff)
			eqgsl_pkg::WB_IDLE:
			begin
				if (wb_req)
					nxt_wb_state = eqgsl_pkg::WB_FETCH;
			end
			eqgsl_pkg::WB_FETCH:
			begin
				nxt_wb_state = eqgsl_pkg::WB_ANSWER;
			end
			eqgsl_pkg::WB_ANSWER:
			begin
				nxt_wb_state = eqgsl_pkg::WB_IDLE;
			end
			default:
			begin
				nxt_wb_state = eqgsl_pkg::WB_IDLE;
			end
		endcase
	end

	// read data mux, unmapped reads zero
	always_comb
	begin
		nxt_rd = '0;
		if (wb_req_in.adr == eqgsl_pkg::OFS_CTRL)
			nxt_rd[eqgsl_pkg::CTRL_ACCEPT_BIT] = accept_ff;
		else if (wb_req_in.adr == eqgsl_pkg::OFS_STATUS)
		begin
			nxt_rd[eqgsl_pkg::WORD_W-1:0]     = last_word_ff;
			nxt_rd[eqgsl_pkg::STAT_INIT_BIT] = initialized_out;
			nxt_rd[eqgsl_pkg::STAT_REJ_BIT]  = rej_ff;
		end
		else if (wb_req_in.adr == eqgsl_pkg::OFS_COUNT)
			nxt_rd[eqgsl_pkg::COUNT_W-1:0] = count_ff;
		else if (gain_hit && initialized_out)
		begin
			// left gain in the low nibble, right gain at its own offset
			nxt_rd[eqgsl_pkg::MAG_W:0] = bank_rd[eqgsl_pkg::MAG_W:0];
			nxt_rd[eqgsl_pkg::GAIN_RIGHT_LSB+:(eqgsl_pkg::MAG_W+1)] = bank_rd[2*(eqgsl_pkg::MAG_W+1)-1:eqgsl_pkg::MAG_W+1];
		end
	end

	// slave state, ack and read data
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wb_state_ff <= eqgsl_pkg::WB_IDLE;
			wb_ack_out  <= 1'b0;
			wb_dat_out  <= '0;
		end
		else
		begin
			wb_state_ff <= nxt_wb_state;
			wb_ack_out  <= (wb_state_ff == eqgsl_pkg::WB_FETCH);
			if (wb_state_ff == eqgsl_pkg::WB_FETCH && !wb_req_in.we)
				wb_dat_out <= nxt_rd;
		end
	end

	// control register write, flat request is a one-cycle pulse
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			accept_ff    <= eqgsl_pkg::CTRL_ACCEPT_RESET;
			soft_flat_ff <= 1'b0;
		end
		else
		begin
			soft_flat_ff <= 1'b0;
			if (wb_state_ff == eqgsl_pkg::WB_FETCH && wr_ctrl)
			begin
				accept_ff    <= wb_req_in.dat[eqgsl_pkg::CTRL_ACCEPT_BIT];
				soft_flat_ff <= wb_req_in.dat[eqgsl_pkg::CTRL_FLAT_BIT];
			end
		end
	end
endmodule // eqgsl_loader

`default_nettype wire

//--- bench/eqgsl_ctrl_model.sv
// controller model framing ten-bit words on the serial pins
`timescale 1ns/1ps
`default_nettype none

module eqgsl_ctrl_model (
	output var logic sclk_out,
	output var logic select_n_out,
	output var logic data_out
);
	// idle: link clock still, select released
	initial
	begin
		sclk_out     = 1'b0;
		select_n_out = 1'b1;
		data_out     = 1'b0;
	end

	// one whole frame, lsb first, select low 120 ns, just under five system cycles
	task send(input logic [9:0] word);
		begin
			select_n_out = 1'b0;
			#20;
			for (int i = 0; i < 10; i++)
			begin
				data_out = word[i];
				#3 sclk_out = 1'b1;
				#3 sclk_out = 1'b0;
			end
			data_out = ~data_out;
			#40 select_n_out = 1'b1;
			#300;
		end
	endtask
endmodule // eqgsl_ctrl_model

`default_nettype wire

//--- bench/eqgsl_loader_monitor.sv
// checker of the loader's bus answers and gain outputs
`timescale 1ns/1ps
`default_nettype none

module eqgsl_loader_monitor (
	input wire logic                        clk_in,
	input wire logic                        rstn_in,
	input wire logic                        select_n_in,
	input wire eqgsl_pkg::eqgsl_wb_req_type wb_req_in,
	input wire logic                        wb_ack_out,
	input wire logic [eqgsl_pkg::DAT_W-1:0] wb_dat_out,
	input wire eqgsl_pkg::eqgsl_bank_type   gain_left_out,
	input wire eqgsl_pkg::eqgsl_bank_type   gain_right_out,
	input wire logic                        initialized_out
);
	logic       sel_ff;
	logic [3:0] since_ff;
	logic       bad;

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	// cycles since select was seen rising
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sel_ff   <= 1'b1;
			since_ff <= 4'hF;
		end
		else
		begin
			sel_ff <= select_n_in;
			if (select_n_in && !sel_ff) since_ff <= 4'h0;
			else if (since_ff != 4'hF) since_ff <= since_ff + 4'h1;
		end
	end

	// any latch showing a magnitude past the table
	always_comb
	begin
		bad = 1'b0;
		for (int i = 0; i < eqgsl_pkg::NUM_BANDS; i++)
		begin
			bad |= (gain_left_out[i].magnitude > eqgsl_pkg::MAG_MAX) | (gain_right_out[i].magnitude > eqgsl_pkg::MAG_MAX);
		end
	end

	property p_ack_delay; $rose(wb_req_in.stb) |-> !wb_ack_out ##1 !wb_ack_out ##1 wb_ack_out; endproperty
	a_ack_delay: assert property (p_ack_delay) else $error("ack not two cycles after request");
	property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_idle; !wb_req_in.cyc [*2] |-> !wb_ack_out; endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
	property p_dat_hold; $changed(wb_dat_out) |-> wb_ack_out && !wb_req_in.we; endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved outside a read ack");
	property p_gain_after_sel;
		$changed({gain_left_out, gain_right_out}) && !wb_ack_out && !$past(wb_ack_out) && !$past(wb_ack_out, 2)
			|-> since_ff inside {[4'h2:4'h9]};
	endproperty
	a_gain_after_sel: assert property (p_gain_after_sel) else $error("gain moved away from select rise");
	property p_zero_uninit; !initialized_out |-> gain_left_out == '0 && gain_right_out == '0; endproperty
	a_zero_uninit: assert property (p_zero_uninit) else $error("gain shown before flat");
	property p_init_sticky; initialized_out |=> initialized_out; endproperty
	a_init_sticky: assert property (p_init_sticky) else $error("initialized dropped");
	property p_flat_zero; $rose(initialized_out) |-> (gain_left_out == '0 && gain_right_out == '0) [*3]; endproperty
	a_flat_zero: assert property (p_flat_zero) else $error("flat left a band off zero");
	property p_gain_legal; !bad; endproperty
	a_gain_legal: assert property (p_gain_legal) else $error("undefined gain latched");

	c_flat: cover property ($rose(initialized_out));
	c_read: cover property (wb_ack_out && !wb_req_in.we);
	c_latch: cover property ($changed(gain_right_out));
endmodule // eqgsl_loader_monitor

bind eqgsl_loader eqgsl_loader_monitor u_monitor (.clk_in(clk_in), .rstn_in(rstn_in), .select_n_in(select_n_in),
	.wb_req_in(wb_req_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .gain_left_out(gain_left_out),
	.gain_right_out(gain_right_out), .initialized_out(initialized_out));

`default_nettype wire

//--- bench/tb_equalizer_gain_serial_loader.sv
// bench for the loader: serial words in, gain banks and registers checked
`timescale 1ns/1ps
`default_nettype none

module tb_equalizer_gain_serial_loader;
	logic                        clk_in = 1'b0;
	logic                        rstn_in = 1'b0;
	eqgsl_pkg::eqgsl_wb_req_type wb_req = '0;
	wire logic                   sclk, sel_n, sdi;
	logic                        wb_ack, init, ini;
	logic [31:0]                 wb_dat, rd;
	eqgsl_pkg::eqgsl_bank_type   gl, gr, el, er;
	logic [3:0]                  b, g;
	logic [9:0]                  w;
	logic [15:0]                 cnt = 16'h0;
	int                          mismatches = 0;
	int                          n_tests = 0;
	int                          cycles = 0;
	logic [9:0]                  bad_w [5] = '{10'h016, 10'h306, 10'h3C6, 10'h317, 10'h318};

	always #12.5 clk_in = ~clk_in;

	eqgsl_loader dut (.clk_in(clk_in), .rstn_in(rstn_in), .serial_clk_in(sclk), .select_n_in(sel_n),
		.serial_data_input_in(sdi), .wb_req_in(wb_req), .wb_ack_out(wb_ack), .wb_dat_out(wb_dat),
		.gain_left_out(gl), .gain_right_out(gr), .initialized_out(init));
	eqgsl_ctrl_model ctrl (.sclk_out(sclk), .select_n_out(sel_n), .data_out(sdi));

	task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// hang guard
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			test_done();
		end
	end

	// one classic cycle, held until ack is sampled
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, dat: d, sel: 4'hF};
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 40);
		rd = wb_dat;
		wb_req <= '0;
		if (n >= 40) mismatches++;
	endtask

	// send a word, update the expected banks, compare banks and status
	task put(input logic [9:0] wd, input logic ok);
		ctrl.send(wd);
		if (ok) cnt++;
		if (ok && wd == eqgsl_pkg::FLAT_WORD) {ini, el, er} = {1'b1, 88'h0};
		if (ok && wd != eqgsl_pkg::FLAT_WORD && wd[8]) el[wd[7:4]-4'h1] = wd[3:0];
		if (ok && wd != eqgsl_pkg::FLAT_WORD && wd[9]) er[wd[7:4]-4'h1] = wd[3:0];
		check("left bank", gl, el);
		check("right bank", gr, er);
		wb(1'b0, eqgsl_pkg::OFS_STATUS, 32'h0);
		check("status word", rd[9:0], wd);
		check("status flags", rd[17:16], {~ok, ini});
	endtask

	initial
	begin
		{ini, el, er} = '0;
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		check("init after reset", init, 1'b0);
		wb(1'b0, eqgsl_pkg::OFS_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h1);
		put(10'h216, 1'b0);
		put(eqgsl_pkg::FLAT_WORD, 1'b1);
		check("init after flat", init, 1'b1);
		put(10'h216, 1'b1);
		put(10'h1BE, 1'b1);
		put(10'h361, 1'b1);
		// each legal gain code once, bands 1 to 11 then 1 and 2, both channels
		for (int i = 0; i < 13; i++)
		begin
			b = 4'(i % 11 + 1);
			g = (i > 6) ? {1'b1, 3'(i - 6)} : {1'b0, 3'(i)};
			put({2'b11, b, g}, 1'b1);
			wb(1'b0, eqgsl_pkg::OFS_GAIN_BASE + {2'b00, b - 4'h1, 2'b00}, 32'h0);
			check("gain reg", rd, {20'h0, er[b-4'h1], 4'h0, el[b-4'h1]});
		end
		foreach (bad_w[k]) put(bad_w[k], 1'b0);
		wb(1'b0, eqgsl_pkg::OFS_COUNT, 32'h0);
		check("applied count", rd[15:0], cnt);
		wb(1'b0, 8'h20, 32'h0);
		check("unmapped read", rd, 32'h0);
		wb(1'b1, eqgsl_pkg::OFS_CTRL, 32'h0);
		ctrl.send(10'h3A3);
		check("left bank off", gl, el);
		wb(1'b1, eqgsl_pkg::OFS_CTRL, 32'h3);
		{el, er} = '0;
		repeat (3) @(posedge clk_in);
		check("left bank flat", gl, el);
		check("right bank flat", gr, er);
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		check("init after second reset", init, 1'b0);
		test_done();
	end
endmodule // tb_equalizer_gain_serial_loader

`default_nettype wire
